// ==== hdl/phy_id_autoneg_adv_regs.sv ====
`timescale 1ns/1ps
// Overview of operation
// [RULE1] identifier spans two read-only registers: org id, model, revision
// [RULE2] identifier may read all zero when the zero option is chosen
// [RULE3] first identifier register shows org id bits 3..18 on bits 15..0
// [RULE4] org id numbered 1 (msb) to 24 (lsb); top two bits dropped
// [RULE5] second identifier register shows org id bits 19..24 on bits 15..10
// [RULE6] six-bit model number sits in bits 9..4, msb at bit 9
// [RULE7] four-bit revision in bits 3..0, msb at bit 3
// [RULE8] software writing advertisement before completion must restart negotiation
// [RULE9] advertisement contents are sent to the partner as local abilities
// [RULE10] bit 15 read-write, reset zero, advertises more next pages
// [RULE11] bit 13 read-write, reset zero, advertises remote fault
// [RULE12] bits 11 and 10 read-write, reset zero: asymmetric and symmetric pause
// [RULE13] bit 9 four-pair ability unsupported, reads zero
// [RULE14] bits 8 and 7 reset from straps, one when no strap
// [RULE15] bits 6 and 5 reset from straps, one when no strap
// [RULE16] bits 4..0 read-write selector, reset to the 802.3 code
// [RULE17] partner register captures abilities received from the partner
// [RULE18] with next pages, partner register updates again after completion
// [RULE19] status bit 5 shows negotiation complete
// [RULE20] writing one to control bit 9 restarts negotiation, bit self-clears
// [RULE21] writes to identifier and partner registers are ignored
module phy_id_autoneg_adv_regs #(
    parameter logic [23:0] ORG_ID = 24'h123456,   // arbitrary value
    parameter logic [5:0] MODEL_NUM = 6'h05,       // arbitrary value
    parameter logic [3:0] REVISION_NUM = 4'h1,     // arbitrary value
    parameter bit ID_ALL_ZERO = 1'b0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic strap_present_i,
    input wire logic [3:0] strap_speed_i,
    input wire logic neg_done_i,
    input wire logic next_pages_en_i,
    input wire logic partner_valid_i,
    input wire logic [15:0] partner_page_i,
    output phy_regs_pkg::ability_page_t local_page_o,
    output logic restart_o
);

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    phy_regs_pkg::mgmt_req_t req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    wire hit_control = req.addr == phy_regs_pkg::OFS_BASIC_CONTROL;
    wire hit_status = req.addr == phy_regs_pkg::OFS_BASIC_STATUS;
    wire hit_id_high = req.addr == phy_regs_pkg::OFS_ID_HIGH;
    wire hit_id_low = req.addr == phy_regs_pkg::OFS_ID_LOW;
    wire hit_advert = req.addr == phy_regs_pkg::OFS_ADVERT;
    wire hit_partner = req.addr == phy_regs_pkg::OFS_PARTNER;

    // ------------------------------------------------------------
    // identifier words
    // ------------------------------------------------------------
    // org id bit n (1 = msb) is ORG_ID[24-n]; bits 1 and 2 are dropped
    wire [23:0] org_id_used = ID_ALL_ZERO ? 24'h000000 : ORG_ID; // [RULE2] [RULE4]
    wire [5:0] model_used = ID_ALL_ZERO ? 6'h00 : MODEL_NUM; // [RULE2]
    wire [3:0] rev_used = ID_ALL_ZERO ? 4'h0 : REVISION_NUM; // [RULE2]
    wire [15:0] org_id_upper_bits = org_id_used[21:6]; // [RULE3]
    wire [5:0] org_id_lower_bits = org_id_used[5:0]; // [RULE5]
    wire [15:0] phy_identifier_high = org_id_upper_bits; // [RULE1]
    wire [15:0] phy_identifier_low = {org_id_lower_bits, model_used, rev_used}; // [RULE1] [RULE6] [RULE7]

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // straps are pins: two flops before use, loaded once after reset release
    logic [4:0] strap_meta;
    logic [4:0] strap_sync;
    logic strap_loaded;
    wire [3:0] strap_value = strap_sync[4] ? strap_sync[3:0] :
                             phy_regs_pkg::STRAP_NONE_DEFAULT; // [RULE14] [RULE15]

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            strap_meta <= 5'h00;
            strap_sync <= 5'h00;
        end else if (ce_i) begin
            strap_meta <= {strap_present_i, strap_speed_i};
            strap_sync <= strap_meta;
        end
    end

    // ------------------------------------------------------------
    // advertisement register
    // ------------------------------------------------------------
    phy_regs_pkg::ability_page_t local_ability_advert;
    wire [15:0] advert_bits = local_ability_advert;
    wire [15:0] advert_written = (req.wdata & phy_regs_pkg::ADVERT_WRITE_MASK) |
                                 (advert_bits & ~phy_regs_pkg::ADVERT_WRITE_MASK);
    // strap load waits two cycles so the synchroniser has settled
    logic [1:0] strap_wait;
    wire strap_load = !strap_loaded && strap_wait == 2'h2;
    phy_regs_pkg::ability_page_t next_advert;

    always_comb begin
        next_advert = local_ability_advert;
        if (req.wr && hit_advert) begin
            next_advert = advert_written; // [RULE10] [RULE11] [RULE12] [RULE16] [RULE13]
        end else if (strap_load) begin
            next_advert.fast_full_duplex = strap_value[3]; // [RULE14]
            next_advert.fast_half_duplex = strap_value[2]; // [RULE14]
            next_advert.ten_full_duplex = strap_value[1]; // [RULE15]
            next_advert.ten_half_duplex = strap_value[0]; // [RULE15]
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            local_ability_advert <= phy_regs_pkg::ADVERT_RESET; // [RULE16]
            strap_wait <= 2'h0;
            strap_loaded <= 1'b0;
        end else if (ce_i) begin
            local_ability_advert <= next_advert;
            if (strap_wait != 2'h2) begin
                strap_wait <= strap_wait + 2'h1;
            end
            // a write in the load cycle wins; the straps then land one cycle later
            if (strap_load && !(req.wr && hit_advert)) begin
                strap_loaded <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // partner abilities, status and restart
    // ------------------------------------------------------------
    logic [15:0] partner_ability_received;
    logic negotiation_done_flag;
    // after completion only next-page exchanges may refresh the partner word
    wire partner_take = partner_valid_i &&
                        (!negotiation_done_flag || next_pages_en_i); // [RULE17] [RULE18]
    wire restart_hit = req.wr && hit_control && req.wdata[phy_regs_pkg::CTRL_RESTART_POS];

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            partner_ability_received <= phy_regs_pkg::PARTNER_RESET;
            negotiation_done_flag <= 1'b0;
            restart_o <= 1'b0;
            local_page_o <= phy_regs_pkg::ADVERT_RESET;
        end else if (ce_i) begin
            if (partner_take) begin
                partner_ability_received <= partner_page_i; // [RULE17] [RULE21]
            end
            // a restart clears completion for one cycle; the flag then follows neg_done_i again
            negotiation_done_flag <= neg_done_i && !restart_hit; // [RULE19] [RULE8]
            restart_o <= restart_hit; // [RULE20]
            local_page_o <= next_advert; // [RULE9]
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // restart bit always reads back as normal mode once taken
    wire [15:0] status_word = {10'h000, negotiation_done_flag, 5'h00}; // [RULE19]
    wire [15:0] read_mux = hit_control ? phy_regs_pkg::REG_ZERO :
                           hit_status ? status_word :
                           hit_id_high ? phy_identifier_high : // [RULE21]
                           hit_id_low ? phy_identifier_low :
                           hit_advert ? advert_bits :
                           hit_partner ? partner_ability_received :
                           phy_regs_pkg::REG_ZERO;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= phy_regs_pkg::REG_ZERO;
        end else if (ce_i) begin
            rdata_o <= req.rd ? read_mux : phy_regs_pkg::REG_ZERO;
        end
    end

endmodule

// ==== hdl/phy_regs_pkg.sv ====
package phy_regs_pkg;

    // ------------------------------------------------------------
    // register indices on the management port
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] OFS_BASIC_STATUS = 5'h01;
    localparam logic [4:0] OFS_ID_HIGH = 5'h02;
    localparam logic [4:0] OFS_ID_LOW = 5'h03;
    localparam logic [4:0] OFS_ADVERT = 5'h04;
    localparam logic [4:0] OFS_PARTNER = 5'h05;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_RESTART_POS = 9;
    localparam int STAT_DONE_POS = 5;
    localparam int ID_ORG_LSB = 10;
    localparam int ID_MODEL_LSB = 4;
    localparam int ID_REV_LSB = 0;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [15:0] ADVERT_RESET = 16'h0001;
    localparam logic [15:0] PARTNER_RESET = 16'h0000;
    // bit 14 reserved, bit 9 unsupported four-pair ability
    localparam logic [15:0] ADVERT_WRITE_MASK = 16'hbdff;
    localparam logic [3:0] STRAP_NONE_DEFAULT = 4'hf;
    localparam logic [15:0] REG_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic more_pages;
        logic spare_reserved;
        logic far_fault;
        logic spare_bit;
        logic asym_flow_ctrl;
        logic sym_flow_ctrl;
        logic four_pair_100m;
        logic fast_full_duplex;
        logic fast_half_duplex;
        logic ten_full_duplex;
        logic ten_half_duplex;
        logic [4:0] technology_selector;
    } ability_page_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } mgmt_req_t;

endpackage

// ==== verif/phy_regs_props.sv ====
`timescale 1ns/1ps
// ------------------------------------------------
// port-level properties of the register bank
// ------------------------------------------------
module phy_regs_props #(
    parameter logic [23:0] ORG_ID = 24'h000000,
    parameter logic [5:0] MODEL_NUM = 6'h00,
    parameter logic [3:0] REVISION_NUM = 4'h0,
    parameter bit ID_ALL_ZERO = 1'b0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic next_pages_en_i,
    input wire logic partner_valid_i,
    input wire logic [15:0] partner_page_i,
    input wire phy_regs_pkg::ability_page_t local_page_o,
    input wire logic restart_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire logic rd_en = ce_i && rd_i;
    wire logic wr_en = ce_i && wr_i;
    wire logic rs_wr = wr_en && addr_i == 5'h00 && wdata_i[9];
    wire logic [15:0] id_hi = ID_ALL_ZERO ? 16'h0000 : ORG_ID[21:6];
    wire logic [15:0] id_lo = ID_ALL_ZERO ? 16'h0000 : {ORG_ID[5:0], MODEL_NUM, REVISION_NUM};
    chk_id_high_word: assert property (rd_en && addr_i == 5'h02 |=> rdata_o == id_hi)
        else $error("identifier high word wrong");
    chk_id_low_word: assert property (rd_en && addr_i == 5'h03 |=> rdata_o == id_lo)
        else $error("identifier low word wrong");
    chk_advert_read: assert property (rd_en && addr_i == 5'h04 |=> rdata_o == $past(local_page_o))
        else $error("advertisement read differs from sent page");
    chk_advert_write: assert property (wr_en && addr_i == 5'h04 |=> local_page_o == ($past(wdata_i) & 16'hbdff))
        else $error("advertisement write not taken");
    chk_fixed_zero: assert property (!local_page_o.four_pair_100m && !local_page_o.spare_reserved)
        else $error("fixed advertisement bit set");
    chk_restart_pulse: assert property (rs_wr |=> restart_o)
        else $error("restart pulse missing");
    chk_restart_cause: assert property (restart_o |-> $past(rs_wr))
        else $error("restart pulse without request");
    chk_partner_capture: assert property (partner_valid_i && ce_i && next_pages_en_i ##1 rd_en && addr_i == 5'h05 && !partner_valid_i |=> rdata_o == $past(partner_page_i, 2))
        else $error("partner page not captured");
    cover property (restart_o);
    cover property (rd_en && addr_i == 5'h05);
    cover property (partner_valid_i && next_pages_en_i);
endmodule
bind phy_id_autoneg_adv_regs phy_regs_props #(.ORG_ID(ORG_ID), .MODEL_NUM(MODEL_NUM),
    .REVISION_NUM(REVISION_NUM), .ID_ALL_ZERO(ID_ALL_ZERO)) i_phy_regs_props (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .next_pages_en_i(next_pages_en_i),
    .partner_valid_i(partner_valid_i), .partner_page_i(partner_page_i),
    .local_page_o(local_page_o), .restart_o(restart_o));

// ==== verif/link_partner_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------
// remote partner: answers a restart after a delay
// ------------------------------------------------
module link_partner_model #(
    parameter int DELAY = 6
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic kick_i,
    input wire logic [15:0] page_i,
    input wire phy_regs_pkg::ability_page_t local_page_i,
    output logic done_o,
    output logic valid_o,
    output logic [15:0] page_o,
    output logic [15:0] heard_o
);
    int cnt;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
            valid_o <= 1'b0;
            page_o <= 16'h0000;
        end else begin
            valid_o <= kick_i || cnt == 2;
            // page only holds while valid, so a late capture sees junk
            page_o <= (kick_i || cnt == 2) ? page_i : ~page_o;
            if (cnt == 2)
                heard_o <= local_page_i;
            if (restart_i)
                done_o <= 1'b0;
            else if (cnt == 1)
                done_o <= 1'b1;
            cnt <= restart_i ? DELAY : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule

// ==== verif/test_phy_id_autoneg_adv_regs.sv ====
`timescale 1ns/1ps
// ------------------------------------------------
// register bank bench
// ------------------------------------------------
module test_phy_id_autoneg_adv_regs;
    localparam logic [23:0] ORG = 24'h9b3c5e;  // arbitrary value
    localparam logic [5:0] MODEL = 6'h2a;  // arbitrary value
    localparam logic [3:0] REV = 4'h9;  // arbitrary value
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [4:0] addr_i = 5'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic strap_present_i = 1'b0;
    logic [3:0] strap_speed_i = 4'h0;
    logic next_pages_en_i = 1'b0;
    logic kick = 1'b0;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic [15:0] page = 16'h0000;
    logic [15:0] seed = 16'ha2e0;
    logic neg_done, pvalid, restart_o;
    logic [15:0] rdata_o, ppage, heard;
    phy_regs_pkg::ability_page_t local_page_o;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [15:0] expq[$];
    always #12.5 clock_i = ~clock_i;
    phy_id_autoneg_adv_regs #(.ORG_ID(ORG), .MODEL_NUM(MODEL), .REVISION_NUM(REV))
        i_phy_id_autoneg_adv_regs (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .strap_present_i(strap_present_i), .strap_speed_i(strap_speed_i),
        .neg_done_i(neg_done), .next_pages_en_i(next_pages_en_i), .partner_valid_i(pvalid),
        .partner_page_i(ppage), .local_page_o(local_page_o), .restart_o(restart_o));
    link_partner_model i_link_partner_model (.clock_i(clock_i), .rst_i(rst_i),
        .restart_i(restart_o), .kick_i(kick), .page_i(page), .local_page_i(local_page_o),
        .done_o(neg_done), .valid_o(pvalid), .page_o(ppage), .heard_o(heard));
    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        expq.push_back(exp);
        op(1'b0, 1'b1, a, 16'h0000);
    endtask
    task automatic idle(input int n);
        repeat (n) op(1'b0, 1'b0, addr_i, wdata_i);
    endtask
    task automatic do_reset(input logic strap, input logic [3:0] speed);
        strap_present_i <= strap;
        strap_speed_i <= speed;
        rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        idle(5);
    endtask
    task automatic kick_page(input logic np, input logic [15:0] pg);
        next_pages_en_i <= np;
        page <= pg;
        kick <= 1'b1;
        idle(1);
        kick <= 1'b0;
        idle(1);
    endtask
    // ------------------------------------------------
    // result watcher
    // ------------------------------------------------
    always @(posedge clock_i) begin
        cycles++;
        if (rd_q)
            check("read data", rdata_o, expq.pop_front());
        if (!rst_i)
            check("restart", {15'h0, restart_o}, {15'h0, wr_q});
        rd_q <= rd_i;
        wr_q <= wr_i && addr_i == 5'h00 && wdata_i[9];
        if (cycles > 2000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        logic [15:0] v, p1, p2;
        do_reset(1'b0, 4'h0);
        rd(5'h02, ORG[21:6]);
        rd(5'h03, {ORG[5:0], MODEL, REV});
        rd(5'h04, 16'h01e1);
        rd(5'h05, 16'h0000);
        op(1'b1, 1'b0, 5'h02, rnd());
        op(1'b1, 1'b0, 5'h03, rnd());
        op(1'b1, 1'b0, 5'h05, rnd());
        op(1'b1, 1'b0, 5'h1f, rnd());
        rd(5'h02, ORG[21:6]);
        rd(5'h03, {ORG[5:0], MODEL, REV});
        rd(5'h05, 16'h0000);
        rd(5'h1f, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'hffff : rnd();
            op(1'b1, 1'b0, 5'h04, v);
            rd(5'h04, v & 16'hbdff);
        end
        // a write while the clock enable is low must leave the register frozen
        ce_i <= 1'b0;
        op(1'b1, 1'b0, 5'h04, ~v);
        ce_i <= 1'b1;
        rd(5'h04, v & 16'hbdff);
        v = rnd() & 16'hbdff;
        p1 = rnd();
        p2 = rnd();
        page <= p1;
        op(1'b1, 1'b0, 5'h04, v);
        op(1'b1, 1'b0, 5'h00, 16'h0200);
        for (int k = 0; k < 20 && neg_done !== 1'b1; k++)
            idle(1);
        idle(2);
        check("partner heard", heard, v);
        rd(5'h05, p1);
        rd(5'h01, 16'h0020);
        kick_page(1'b0, p2);
        rd(5'h05, p1);
        kick_page(1'b1, p2);
        rd(5'h05, p2);
        idle(2);
        v = rnd();
        do_reset(1'b1, v[3:0]);
        rd(5'h04, {7'h00, v[3:0], 5'h01});
        idle(3);
        results();
    end
endmodule
